// ===== hw/cia_core.sv
/*
  CPU interrupt and exception acceptance: masks and prioritises requests, saves
  PC and status, writes event codes, updates the status word and redirects the PC.
  Assumes the pipeline reports instruction boundaries and exceptions on sys_clk,
  and the interrupt controller presents one prioritised request.
*/
// What this block does
// RULE_01: Level request needs mask below level, unblocked
// RULE_02: Level code is 0x200 plus level times 0x20
// RULE_03: Save next PC and status on accept
// RULE_04: Set block, mode, bank; jump base+0x600
// RULE_05: Mask field untouched by interrupt acceptance
// RULE_06: IRQ pin accepted by mask, writes both codes
// RULE_07: INT pin accepted by mask, writes both codes
// RULE_08: Maskable interrupts only at instruction boundaries
// RULE_09: Module request accepted when mask below level
// RULE_10: Blocked holds off; pending taken after unblock
// RULE_11: Sleep or standby accepts despite block bit
// RULE_12: Blocked NMI needs block-override bit set
// RULE_13: Blocked exception branches to reset address
// RULE_14: No user break trap while blocked
// RULE_15: Re-executing saved PC handles delay slots
// RULE_16: Completed saved PC: next, target, or slot
// RULE_17: Reset values for base, status, PC
// RULE_18: Return loads PC and status from saves
// RULE_19: NMI ignores mask, code 0x1c0, top priority
// RULE_20: Controller presents only its highest request
module cia_core #(
  parameter int LEVEL_W = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins from outside the clock domain
  input wire logic nmi_pin,
  input wire logic [LEVEL_W-1:0] encoded_level_inputs,
  // Interrupt controller and control inputs
  input wire cia_pkg::cia_req_s ctl_req,
  input wire logic block_override_bit,
  input wire logic sleep_mode,
  // Pipeline events
  input wire logic insn_boundary,
  input wire logic [31:0] boundary_next_pc,
  input wire cia_pkg::cia_exc_s exc,
  input wire logic rte_req,
  input wire logic status_wr,
  input wire cia_pkg::cia_status_s status_wdata,
  input wire logic vector_base_wr,
  input wire logic [31:0] vector_base_wdata,
  // Architectural state
  output cia_pkg::cia_status_s status_word,
  output logic [31:0] saved_pc,
  output cia_pkg::cia_status_s saved_status,
  output logic [31:0] vector_base,
  output logic [11:0] interrupt_event_code,
  output logic [11:0] interrupt_event_code_alt,
  output logic [11:0] exception_event_code,
  // PC redirection
  output logic redirect,
  output logic [31:0] redirect_pc,
  output logic int_taken,
  output logic exc_taken
);

  ////////////////////////////////////////////////////////////////////////////
  // Saved-PC selection for exceptions

  // Chooses the PC that the handler returns to
  function automatic logic [31:0] exc_return_pc(input cia_pkg::cia_exc_s e);
    logic [31:0] r;
    r = e.next_pc;
    if (e.redo) begin
      // RULE_15: re-executing saved PC
      r = e.pc;
      if (e.in_slot) begin
        r = e.cond_failed ? e.slot_pc : e.branch_pc;
      end
    end else if (e.delayed_cond) begin
      // RULE_16: completed-type saved PC
      r = e.cond_failed ? e.slot_pc : e.target_pc;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [cia_pkg::SYNC_STAGES-1:0] nmi_sync;     // NMI pin shift chain
  logic [LEVEL_W-1:0] lvl_sync [cia_pkg::SYNC_STAGES]; // Level pin chain
  logic [cia_pkg::SYNC_STAGES-1:0] next_nmi_sync;
  logic [LEVEL_W-1:0] next_lvl_sync [cia_pkg::SYNC_STAGES];
  logic nmi_level;                // Debounced NMI level
  logic [LEVEL_W-1:0] pin_level;  // Debounced encoded level
  logic [LEVEL_W-1:0] next_pin_level;
  logic nmi_pending;              // NMI edge waiting to be taken
  logic next_nmi_pending;

  // Shift pins in; a change counts when stages two and three agree
  always_comb begin
    next_nmi_sync = {nmi_sync[cia_pkg::SYNC_STAGES-2:0], nmi_pin};
    next_lvl_sync[0] = encoded_level_inputs;
    for (int i = 1; i < cia_pkg::SYNC_STAGES; i++) begin
      next_lvl_sync[i] = lvl_sync[i-1];
    end
    next_pin_level = pin_level;
    if (lvl_sync[1] == lvl_sync[2]) begin
      next_pin_level = lvl_sync[2];
    end
  end

  // Register the synchroniser stages
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nmi_sync <= '0;
      pin_level <= '0;
      for (int i = 0; i < cia_pkg::SYNC_STAGES; i++) begin
        lvl_sync[i] <= '0;
      end
    end else begin
      nmi_sync <= next_nmi_sync;
      pin_level <= next_pin_level;
      for (int i = 0; i < cia_pkg::SYNC_STAGES; i++) begin
        lvl_sync[i] <= next_lvl_sync[i];
      end
    end
  end

  // Agreed NMI level from the two later stages
  logic nmi_prev;
  logic next_nmi_prev;
  assign nmi_level = (nmi_sync[1] == nmi_sync[2]) ? nmi_sync[2] : nmi_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification

  logic blocked;         // Block bit holds interrupts off
  logic lvl_ok;          // Encoded level request qualifies
  logic ctl_ok;          // Controller request qualifies
  logic nmi_ok;          // NMI may be taken now
  logic use_pin;         // Encoded level wins over controller request

  always_comb begin
    // RULE_10: block bit holds off acceptance
    // RULE_11: sleep or standby overrides block bit
    blocked = status_word.bl && !sleep_mode;
    // RULE_01: level beats mask, unblocked
    lvl_ok = (status_word.interrupt_mask_field < pin_level) && !blocked;
    // RULE_06: IRQ pin mask compare
    // RULE_07: INT pin mask compare
    // RULE_09: module level mask compare
    // RULE_20: one prioritised request only
    ctl_ok = ctl_req.valid && (status_word.interrupt_mask_field < ctl_req.level) && !blocked;
    use_pin = lvl_ok && (!ctl_ok || (pin_level >= ctl_req.level));
    // RULE_12: blocked NMI needs override
    // RULE_19: NMI ignores mask field
    nmi_ok = nmi_pending && (!status_word.bl || sleep_mode || block_override_bit);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state update

  cia_pkg::cia_status_s next_status_word;
  cia_pkg::cia_status_s next_saved_status;
  logic [31:0] next_saved_pc;
  logic [31:0] next_vector_base;
  logic [11:0] next_int_code;
  logic [11:0] next_int_code_alt;
  logic [11:0] next_exc_code;
  logic next_redirect;
  logic [31:0] next_redirect_pc;
  logic next_int_taken;
  logic next_exc_taken;
  logic take_int;   // An interrupt is accepted this cycle

  // Compute next state; exception beats return, return beats interrupt
  always_comb begin
    next_status_word = status_word;
    next_saved_status = saved_status;
    next_saved_pc = saved_pc;
    next_vector_base = vector_base;
    next_int_code = interrupt_event_code;
    next_int_code_alt = interrupt_event_code_alt;
    next_exc_code = exception_event_code;
    next_redirect = 1'b0;
    next_redirect_pc = redirect_pc;
    next_int_taken = 1'b0;
    next_exc_taken = 1'b0;
    next_nmi_prev = nmi_level;
    // NMI edge sets pending; a new edge wins over the clear
    next_nmi_pending = nmi_pending;
    take_int = 1'b0;
    // Software writes of status word and vector base
    if (status_wr) begin
      next_status_word = status_wdata;
    end
    if (vector_base_wr) begin
      next_vector_base = vector_base_wdata;
    end
    if (exc.valid) begin
      if (status_word.bl) begin
        // RULE_14: no user break while blocked
        if (!exc.user_break) begin
          // RULE_13: blocked exception goes to reset address
          next_redirect = 1'b1;
          next_redirect_pc = cia_pkg::RESET_PC;
          next_exc_taken = 1'b1;
        end
      end else begin
        // Normal exception entry
        next_saved_pc = exc_return_pc(exc);
        next_saved_status = status_word;
        next_exc_code = exc.code;
        next_status_word = status_word;
        next_status_word.bl = 1'b1;
        next_status_word.md = 1'b1;
        next_status_word.rb = 1'b1;
        next_redirect = 1'b1;
        next_redirect_pc = vector_base + exc.offset;
        next_exc_taken = 1'b1;
      end
    end else if (rte_req) begin
      // RULE_18: return restores PC and status
      next_status_word = saved_status;
      next_redirect = 1'b1;
      next_redirect_pc = saved_pc;
    end else if (insn_boundary && (nmi_ok || lvl_ok || ctl_ok)) begin
      // RULE_08: only at instruction boundaries
      take_int = 1'b1;
      // RULE_03: save next PC and status
      next_saved_pc = boundary_next_pc;
      next_saved_status = status_word;
      if (nmi_ok) begin
        // RULE_19: NMI code, top priority
        next_int_code = cia_pkg::NMI_CODE;
      end else if (use_pin) begin
        // RULE_02: level event code
        next_int_code = cia_pkg::LEVEL_CODE_BASE
          + 12'(cia_pkg::LEVEL_CODE_STEP * 12'(pin_level));
      end else begin
        next_int_code = ctl_req.code;
        // RULE_06: IRQ writes both codes
        // RULE_07: INT writes both codes
        if (ctl_req.kind != cia_pkg::SRC_MODULE) begin
          next_int_code_alt = ctl_req.code;
        end
      end
      // RULE_04: set block, mode, bank and vector
      // RULE_05: mask field left as it was
      next_status_word = status_word;
      next_status_word.bl = 1'b1;
      next_status_word.md = 1'b1;
      next_status_word.rb = 1'b1;
      next_redirect = 1'b1;
      next_redirect_pc = vector_base + cia_pkg::INT_VECTOR_OFFSET;
      next_int_taken = 1'b1;
    end
    // Clear pending NMI when taken, but a fresh edge sets it again
    if (take_int && nmi_ok) begin
      next_nmi_pending = 1'b0;
    end
    if (nmi_level && !nmi_prev) begin
      next_nmi_pending = 1'b1;
    end
  end

  // Register architectural state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // RULE_17: reset values
      status_word <= '0;
      status_word.md <= 1'b1;
      status_word.bl <= 1'b1;
      status_word.rb <= 1'b1;
      status_word.interrupt_mask_field <= cia_pkg::RESET_INTERRUPT_MASK_FIELD;
      vector_base <= cia_pkg::RESET_VECTOR_BASE;
      redirect <= 1'b1;
      redirect_pc <= cia_pkg::RESET_PC;
      saved_pc <= '0;
      saved_status <= '0;
      interrupt_event_code <= '0;
      interrupt_event_code_alt <= '0;
      exception_event_code <= '0;
      int_taken <= 1'b0;
      exc_taken <= 1'b0;
      nmi_prev <= 1'b0;
      nmi_pending <= 1'b0;
    end else begin
      status_word <= next_status_word;
      vector_base <= next_vector_base;
      redirect <= next_redirect;
      redirect_pc <= next_redirect_pc;
      saved_pc <= next_saved_pc;
      saved_status <= next_saved_status;
      interrupt_event_code <= next_int_code;
      interrupt_event_code_alt <= next_int_code_alt;
      exception_event_code <= next_exc_code;
      int_taken <= next_int_taken;
      exc_taken <= next_exc_taken;
      nmi_prev <= next_nmi_prev;
      nmi_pending <= next_nmi_pending;
    end
  end

endmodule // cia_core

// ===== inc/cia_pkg.sv
/*
  Constants and carrier types for the CPU interrupt and exception acceptance unit.
  Assumes a single 10 MHz clock and a synchronous, active-high reset.
*/
package cia_pkg;

  // Reset values
  localparam logic [31:0] RESET_PC = 32'ha0000000;
  localparam logic [31:0] RESET_VECTOR_BASE = 32'h00000000;
  localparam logic [3:0] RESET_INTERRUPT_MASK_FIELD = 4'hf;

  // Vector offsets and event codes
  localparam logic [31:0] INT_VECTOR_OFFSET = 32'h00000600;
  localparam logic [11:0] LEVEL_CODE_BASE = 12'h200;
  localparam logic [11:0] LEVEL_CODE_STEP = 12'h020;
  localparam logic [11:0] NMI_CODE = 12'h1c0;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Status word layout, bit 31 down to bit 0
  typedef struct packed {
    logic top;           // Bit 31
    logic md;            // Privilege mode bit
    logic rb;            // Bank select bit
    logic bl;            // Block bit
    logic [19:0] mid;    // Bits 27..8
    logic [3:0] interrupt_mask_field;   // Interrupt mask field
    logic [3:0] low;     // Bits 3..0
  } cia_status_s;

  // Source class of a controller request
  typedef enum logic [1:0] {
    SRC_MODULE,
    SRC_IRQ,
    SRC_INT
  } cia_src_e;

  // Single highest-priority request from the interrupt controller
  typedef struct packed {
    logic valid;
    cia_src_e kind;
    logic [3:0] level;
    logic [11:0] code;
  } cia_req_s;

  // Exception report from the pipeline with the PCs needed for the saved PC
  typedef struct packed {
    logic valid;          // One-cycle pulse
    logic redo;           // Re-executing type when set, completed type otherwise
    logic user_break;     // User break trap
    logic [11:0] code;    // Exception event code
    logic [31:0] offset;  // Vector offset from the vector base
    logic [31:0] pc;      // PC of the instruction that raised it
    logic [31:0] next_pc; // PC of the following instruction
    logic in_slot;        // Raised in a delay slot
    logic delayed_cond;   // Raised by a delayed conditional instruction
    logic cond_failed;    // Condition of that delayed branch failed
    logic [31:0] branch_pc;   // PC of the delayed branch before the slot
    logic [31:0] target_pc;   // Branch destination
    logic [31:0] slot_pc;     // PC of the delay slot
  } cia_exc_s;

endpackage

// ===== tb/cia_core_props.sv
/* Checker for the interrupt acceptance core.
   Sees only core ports; attached by the bind at the foot. */
module cia_core_props #(
  parameter int LEVEL_W = 4
) (
  // Clock, reset and requests
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic nmi_pin,
  input wire logic [LEVEL_W-1:0] encoded_level_inputs,
  input wire cia_pkg::cia_req_s ctl_req,
  input wire logic block_override_bit,
  input wire logic sleep_mode,
  input wire logic insn_boundary,
  input wire logic [31:0] boundary_next_pc,
  input wire cia_pkg::cia_exc_s exc,
  input wire logic rte_req,
  // State and redirection
  input wire cia_pkg::cia_status_s status_word,
  input wire logic [31:0] saved_pc,
  input wire cia_pkg::cia_status_s saved_status,
  input wire logic [31:0] vector_base,
  input wire logic [11:0] interrupt_event_code,
  input wire logic [11:0] interrupt_event_code_alt,
  input wire logic redirect,
  input wire logic [31:0] redirect_pc,
  input wire logic int_taken,
  input wire logic exc_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_reset; $past(rst) |-> status_word.interrupt_mask_field == 4'hf && status_word.bl && status_word.md
    && status_word.rb && vector_base == 32'h0 && redirect_pc == cia_pkg::RESET_PC; endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_entry; int_taken |-> redirect && status_word.bl && status_word.md && status_word.rb
    && redirect_pc == $past(vector_base) + cia_pkg::INT_VECTOR_OFFSET; endproperty
  a_entry: assert property (p_entry) else $error("entry wrong");
  property p_mask; int_taken |-> status_word.interrupt_mask_field == $past(status_word.interrupt_mask_field); endproperty
  a_mask: assert property (p_mask) else $error("mask changed");
  property p_save; int_taken |-> saved_pc == $past(boundary_next_pc)
    && saved_status == $past(status_word); endproperty
  a_save: assert property (p_save) else $error("save wrong");
  property p_bnd; int_taken |-> $past(insn_boundary); endproperty
  a_bnd: assert property (p_bnd) else $error("off boundary");
  property p_blk; int_taken && $past(status_word.bl) |-> $past(sleep_mode || block_override_bit);
  endproperty
  a_blk: assert property (p_blk) else $error("taken while blocked");
  sequence s_quiet; encoded_level_inputs == '0 && !nmi_pin && insn_boundary && ctl_req.valid;
  endsequence
  property p_ctl; s_quiet ##0 (ctl_req.kind != cia_pkg::SRC_MODULE && !status_word.bl
    && status_word.interrupt_mask_field < ctl_req.level && !exc.valid && !rte_req) |=> int_taken
    && interrupt_event_code == $past(ctl_req.code) && interrupt_event_code_alt == $past(ctl_req.code);
  endproperty
  a_ctl: assert property (p_ctl) else $error("pin request lost");
  property p_low; s_quiet ##0 (status_word.interrupt_mask_field >= ctl_req.level) |=> !int_taken; endproperty
  a_low: assert property (p_low) else $error("masked request taken");
  property p_xblk; exc.valid && !exc.user_break && status_word.bl |=> exc_taken
    && redirect_pc == cia_pkg::RESET_PC; endproperty
  a_xblk: assert property (p_xblk) else $error("blocked exception wrong");
  property p_ubrk; exc.valid && exc.user_break && status_word.bl |=> !exc_taken; endproperty
  a_ubrk: assert property (p_ubrk) else $error("break while blocked");
  property p_rte; rte_req && !exc.valid |=> redirect && redirect_pc == $past(saved_pc)
    && status_word == $past(saved_status); endproperty
  a_rte: assert property (p_rte) else $error("return wrong");
  c_int: cover property (int_taken && $past(status_word.bl));
  c_exc: cover property (exc_taken && redirect_pc == cia_pkg::RESET_PC);
  c_rte: cover property (rte_req ##1 redirect);
endmodule // cia_core_props

bind cia_core cia_core_props #(.LEVEL_W(LEVEL_W)) i_cia_core_props (.sys_clk, .rst, .nmi_pin,
  .encoded_level_inputs, .ctl_req, .block_override_bit, .sleep_mode, .insn_boundary,
  .boundary_next_pc, .exc, .rte_req, .status_word, .saved_pc, .saved_status, .vector_base,
  .interrupt_event_code, .interrupt_event_code_alt, .redirect, .redirect_pc, .int_taken,
  .exc_taken);

// ===== tb/cia_ic_model.sv
/* Interrupt controller stand-in: offers one request, the highest pending.
   Runs on the core clock; a level of 0 means the source is idle. */
module cia_ic_model #(
  parameter logic [11:0] IRQ_CODE = 12'h600,
  parameter logic [11:0] INT_CODE = 12'h620,
  parameter logic [11:0] MOD_CODE = 12'h640
) (
  // Clock and source levels
  input wire logic sys_clk,
  input wire logic [3:0] irq_lvl,
  input wire logic [3:0] int_lvl,
  input wire logic [3:0] mod_lvl,
  // Request to the core
  output cia_pkg::cia_req_s ctl_req
);
  timeunit 1ns;
  timeprecision 1ns;
  cia_pkg::cia_req_s next_ctl_req; // Request for the next cycle
  always_comb begin
    next_ctl_req = cia_pkg::cia_req_s'(~ctl_req); // Idle fields toggle, never hold
    next_ctl_req.valid = 1'b0;
    if (irq_lvl != 4'h0 && irq_lvl >= int_lvl && irq_lvl >= mod_lvl) begin
      next_ctl_req = '{1'b1, cia_pkg::SRC_IRQ, irq_lvl, IRQ_CODE};
    end else if (int_lvl != 4'h0 && int_lvl >= mod_lvl) begin
      next_ctl_req = '{1'b1, cia_pkg::SRC_INT, int_lvl, INT_CODE};
    end else if (mod_lvl != 4'h0) begin
      next_ctl_req = '{1'b1, cia_pkg::SRC_MODULE, mod_lvl, MOD_CODE};
    end
  end
  // Register the offer
  always_ff @(posedge sys_clk) begin
    ctl_req <= next_ctl_req;
  end
endmodule // cia_ic_model

// ===== tb/cpu_interrupt_acceptance_tb_top.sv
/* Bench: drives the core and the controller stand-in through interrupt,
   return and exception sequences. Assumes cia_pkg is compiled first. */
module cpu_interrupt_acceptance_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] VB = 32'h8000_0000; // Vector base under test
  localparam logic [31:0] NPC = 32'h0000_1234; // Next PC at boundaries
  localparam logic [11:0] IRQ_C = 12'h600, INT_C = 12'h620, MOD_C = 12'h640;
  logic sys_clk = 1'b0, rst = 1'b1, nmi_pin = 1'b0, block_override_bit = 1'b0, sleep_mode = 1'b0;
  logic insn_boundary = 1'b0, rte_req = 1'b0, status_wr = 1'b0, vector_base_wr = 1'b0;
  logic [3:0] lvl = 4'h0, irq_l = 4'h0, int_l = 4'h0, mod_l = 4'h0, mask_v;
  logic [31:0] vector_base_wdata = '0, saved_pc, vector_base, redirect_pc;
  cia_pkg::cia_status_s status_wdata = '0, status_word, saved_status;
  cia_pkg::cia_exc_s exc = '0;
  cia_pkg::cia_req_s ctl_req;
  logic [11:0] iec, iec_alt, eec, alt_v = 12'h0;
  logic redirect, int_taken, exc_taken, bl_v;
  logic [31:0] npc = NPC; // Next PC offered at boundaries, moves per test
  int n_mismatch = 0, cmp_count = 0;
  always #50 sys_clk = ~sys_clk;
  cia_ic_model i_cia_ic_model (.sys_clk, .irq_lvl(irq_l), .int_lvl(int_l), .mod_lvl(mod_l),
    .ctl_req);
  cia_core i_cia_core (.sys_clk, .rst, .nmi_pin, .encoded_level_inputs(lvl), .ctl_req,
    .block_override_bit, .sleep_mode, .insn_boundary, .boundary_next_pc(npc), .exc, .rte_req,
    .status_wr, .status_wdata, .vector_base_wr, .vector_base_wdata, .status_word, .saved_pc,
    .saved_status, .vector_base, .interrupt_event_code(iec), .interrupt_event_code_alt(iec_alt),
    .exception_event_code(eec), .redirect, .redirect_pc, .int_taken, .exc_taken);
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Inputs move 10 ns after the edge
  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  task automatic bnd();
    insn_boundary = 1'b1;
    step();
    insn_boundary = 0;
  endtask
  task automatic ret();
    rte_req = 1'b1;
    step();
    rte_req = 1'b0;
  endtask
  // Status write with md and rb set
  task automatic wsr(input logic bl, input logic [3:0] im);
    status_wdata = '0;
    {status_wdata.md, status_wdata.rb, status_wdata.bl, status_wdata.interrupt_mask_field} = {2'b11, bl, im};
    {bl_v, mask_v} = {bl, im};
    status_wr = 1'b1;
    step();
    status_wr = 1'b0;
  endtask
  // One boundary with sources set, then return if taken
  task automatic itest(input string nm, input logic take, input logic [11:0] code, alt);
    npc = npc + 32'h4;
    bnd();
    chk({nm, " taken"}, int_taken, take);
    if (take) begin
      chk({nm, " code"}, iec, code);
      chk({nm, " alt"}, iec_alt, alt);
      chk({nm, " spc"}, saved_pc, npc);
      chk({nm, " ssr"}, saved_status.interrupt_mask_field, mask_v);
      chk({nm, " interrupt_mask_field"}, status_word.interrupt_mask_field, mask_v);
      chk({nm, " bits"}, {status_word.bl, status_word.md, status_word.rb}, 3'b111);
      chk({nm, " vec"}, redirect_pc, VB + 32'h600);
      chk({nm, " redirect"}, redirect, 1'b1);
    end
    {lvl, irq_l, int_l, mod_l, nmi_pin} = '0;
    step(5);
    if (take) begin
      ret();
      chk({nm, " rte pc"}, redirect_pc, npc);
      chk({nm, " rte sr"}, {status_word.bl, status_word.interrupt_mask_field}, {bl_v, mask_v});
    end
    $display("Done %s", nm);
  endtask
  // Exception; f is redo, in_slot, delayed_cond, cond_failed
  task automatic xtest(input string nm, input logic ub, input logic [3:0] f, input logic [31:0] pc);
    exc = '0;
    {exc.redo, exc.in_slot, exc.delayed_cond, exc.cond_failed, exc.user_break} = {f, ub};
    {exc.code, exc.offset, exc.pc, exc.next_pc} = {12'h180, 32'h100, 32'h100, 32'h104};
    {exc.branch_pc, exc.target_pc, exc.slot_pc, exc.valid} = {32'hfc, 32'h200, 32'h300, 1'b1};
    step();
    exc.valid = 1'b0;
    chk({nm, " taken"}, exc_taken, !(ub && bl_v));
    if (bl_v && !ub) chk({nm, " pc"}, redirect_pc, cia_pkg::RESET_PC);
    if (!bl_v) begin
      chk({nm, " spc"}, saved_pc, pc);
      chk({nm, " code"}, eec, 12'h180);
      chk({nm, " vec"}, redirect_pc, VB + 32'h100);
      ret();
    end
    $display("Done %s", nm);
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the roughly 160 cycles the tests need
  initial begin
    #200_000;
    n_mismatch++;
    results();
  end
  initial begin
    step(4);
    rst = 1'b0;
    step();
    chk("reset sr", {status_word.md, status_word.rb, status_word.bl, status_word.interrupt_mask_field}, 7'h7f);
    chk("reset vb", vector_base, 32'h0);
    chk("reset pc", redirect_pc, cia_pkg::RESET_PC);
    {vector_base_wdata, vector_base_wr} = {VB, 1'b1};
    step();
    vector_base_wr = 1'b0;
    wsr(1'b0, 4'h3);
    for (int l = 3; l < 16; l += 4) begin
      lvl = 4'(l);
      step(5);
      itest("level", l > 3, 12'h200 + 12'(l * 32), alt_v);
    end
    irq_l = 4'h5;
    step(2);
    itest("irq", 1'b1, IRQ_C, IRQ_C);
    int_l = 4'h6;
    step(2);
    itest("int", 1'b1, INT_C, INT_C);
    alt_v = INT_C;
    mod_l = 4'h3;
    step(2);
    itest("mod low", 1'b0, MOD_C, alt_v);
    mod_l = 4'hf;
    step(2);
    itest("mod", 1'b1, MOD_C, alt_v);
    lvl = 4'h5;
    irq_l = 4'h4;
    step(5);
    itest("pin wins", 1'b1, 12'h2a0, alt_v);
    wsr(1'b1, 4'h0);
    lvl = 4'h5;
    step(5);
    bnd();
    chk("blocked", int_taken, 1'b0);
    wsr(1'b0, 4'h0);
    itest("unblock", 1'b1, 12'h2a0, alt_v);
    sleep_mode = 1'b1;
    wsr(1'b1, 4'h0);
    lvl = 4'h5;
    step(5);
    itest("sleep", 1'b1, 12'h2a0, alt_v);
    sleep_mode = 1'b0;
    wsr(1'b1, 4'hf);
    nmi_pin = 1'b1;
    step(6);
    bnd();
    chk("nmi held", int_taken, 1'b0);
    block_override_bit = 1'b1;
    itest("nmi", 1'b1, 12'h1c0, alt_v);
    block_override_bit = 1'b0;
    wsr(1'b0, 4'h0);
    xtest("redo", 1'b0, 4'b1000, 32'h100);
    xtest("redo slot", 1'b0, 4'b1100, 32'hfc);
    xtest("redo slot nt", 1'b0, 4'b1101, 32'h300);
    xtest("done", 1'b0, 4'b0000, 32'h104);
    xtest("done cond", 1'b0, 4'b0010, 32'h200);
    xtest("done cond nt", 1'b0, 4'b0011, 32'h300);
    wsr(1'b1, 4'h0);
    xtest("break blocked", 1'b1, 4'h0, 32'h0);
    xtest("exc blocked", 1'b0, 4'h0, 32'h0);
    results();
  end
endmodule // cpu_interrupt_acceptance_tb_top
